// ---- design/fcd_map.svh ----
// address, data and timing constants for the flash command host
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH
`define FCD_ADDR_UNLOCK1   20'h00555
`define FCD_ADDR_UNLOCK2   20'h002aa
`define FCD_ADDR_QUERY     20'h00055
`define FCD_ADDR_ANY       20'h00000
`define FCD_ID_OFS0        20'h00000
`define FCD_ID_OFS1        20'h00001
`define FCD_ID_OFS2        20'h0000e
`define FCD_ID_OFS3        20'h0000f
`define FCD_OFS_SEC_PROT   20'h00002
`define FCD_OFS_REGION     20'h00003
`define FCD_SECTOR_LSB     12
`define FCD_D_UNLOCK1      8'haa
`define FCD_D_UNLOCK2      8'h55
`define FCD_D_RESET        8'hf0
`define FCD_D_PROGRAM      8'ha0
`define FCD_D_BYPASS       8'h20
`define FCD_D_AUTOSEL      8'h90
`define FCD_D_ERASE_SETUP  8'h80
`define FCD_D_CHIP_ERASE   8'h10
`define FCD_D_SECTOR_ERASE 8'h30
`define FCD_D_SUSPEND      8'hb0
`define FCD_D_RESUME       8'h30
`define FCD_D_REGION_ENTER 8'h88
`define FCD_D_QUERY        8'h98
`define FCD_D_UNPROT_SETUP 8'he0
`define FCD_D_UNPROT_ON    8'h01
`define FCD_D_ZERO         8'h00
// bus cycle phase lengths in ns and in 8 ns clocks
`define FCD_CLK_NS         8
`define FCD_T_SETUP_NS     16
`define FCD_T_PULSE_NS     48
`define FCD_T_HOLD_NS      16
`define FCD_T_READ_NS      64
`define FCD_CYC(ns)        (((ns) + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`endif

// ---- design/fcd_pkg.sv ----
// types for the flash command host
`default_nettype none
package fcd_pkg;
    typedef enum logic [3:0] {
        FCD_CMD_RESET, FCD_CMD_PROGRAM, FCD_CMD_BYPASS_ENTER, FCD_CMD_BYPASS_PROGRAM,
        FCD_CMD_BYPASS_EXIT, FCD_CMD_CHIP_ERASE, FCD_CMD_SECTOR_ERASE, FCD_CMD_SUSPEND,
        FCD_CMD_RESUME, FCD_CMD_AUTOSEL_ID, FCD_CMD_AUTOSEL_QUERY, FCD_CMD_REGION_ENTER,
        FCD_CMD_REGION_EXIT, FCD_CMD_QUERY, FCD_CMD_UNPROTECT, FCD_CMD_READ
    } fcd_cmd_e;
    typedef struct packed {
        logic [19:0] addr;
        logic [31:0] data;
        logic        wr;
        logic        last;
    } fcd_cycle_s;
    typedef struct packed {
        fcd_cmd_e    cmd;
        logic [19:0] addr;
        logic [31:0] data;
        logic        flag;
    } fcd_req_s;
endpackage : fcd_pkg
`default_nettype wire

// ---- design/fcd_bus_cycle.sv ----
// one asynchronous flash bus cycle: strobes, address, data pins
`timescale 1ns/100ps
`default_nettype none
`include "fcd_map.svh"
module fcd_bus_cycle (
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire logic               i_start,
    input  wire fcd_pkg::fcd_cycle_s i_cyc,
    input  wire logic [31:0]        i_dq,
    output logic                    o_busy,
    output logic                    o_done,
    output logic [31:0]             o_rdata,
    output logic [19:0]             o_addr,
    output logic [31:0]             o_dq,
    output logic                    o_dq_oe_n,
    output logic                    o_ce_n,
    output logic                    o_we_n,
    output logic                    o_oe_n
);
    typedef enum logic [1:0] {FCB_IDLE, FCB_SETUP, FCB_PULSE, FCB_HOLD} fcd_cyc_state_e;
    localparam logic [3:0] SETUP_N = 4'(`FCD_CYC(`FCD_T_SETUP_NS));
    localparam logic [3:0] PULSE_N = 4'(`FCD_CYC(`FCD_T_PULSE_NS));
    localparam logic [3:0] READ_N  = 4'(`FCD_CYC(`FCD_T_READ_NS));
    localparam logic [3:0] HOLD_N  = 4'(`FCD_CYC(`FCD_T_HOLD_NS));
    fcd_cyc_state_e state, next_state;
    logic [3:0]  cnt, next_cnt;
    logic        wr, next_wr;
    logic [31:0] dq_s1, dq_s2, rdata, next_rdata;
    logic [19:0] next_addr;
    logic [31:0] next_dq;
    logic        next_done, next_ce_n, next_we_n, next_oe_n, next_dq_oe_n;

    // pin input double synchroniser
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dq_s1 <= 32'h0;
            dq_s2 <= 32'h0;
        end else begin
            dq_s1 <= i_dq;
            dq_s2 <= dq_s1;
        end
    end

    // cycle sequencing; address set before strobe falls, data held past rise
    always_comb begin
        next_state = state; next_cnt = cnt; next_wr = wr; next_rdata = rdata;
        next_addr = o_addr; next_dq = o_dq; next_done = 1'b0;
        next_ce_n = o_ce_n; next_we_n = o_we_n; next_oe_n = o_oe_n;
        next_dq_oe_n = o_dq_oe_n;
        if (cnt != 4'h0) next_cnt = cnt - 4'h1;
        unique case (state)
            FCB_IDLE: if (i_start) begin
                next_state = FCB_SETUP; next_cnt = SETUP_N; next_wr = i_cyc.wr;
                next_addr = i_cyc.addr; next_dq = i_cyc.data;
                next_dq_oe_n = ~i_cyc.wr; next_ce_n = 1'b0;
            end
            FCB_SETUP: if (cnt == 4'h0) begin
                next_state = FCB_PULSE;
                next_cnt = wr ? PULSE_N : READ_N;
                next_we_n = ~wr; next_oe_n = wr;
            end
            FCB_PULSE: if (cnt == 4'h0) begin
                next_state = FCB_HOLD; next_cnt = HOLD_N;
                next_we_n = 1'b1; next_oe_n = 1'b1;
                if (!wr) next_rdata = dq_s2;
            end
            FCB_HOLD: if (cnt == 4'h0) begin
                next_state = FCB_IDLE; next_done = 1'b1;
                next_ce_n = 1'b1; next_dq_oe_n = 1'b1;
            end
        endcase
    end

    // register state and pins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= FCB_IDLE; cnt <= 4'h0; wr <= 1'b0; rdata <= 32'h0;
            o_addr <= 20'h0; o_dq <= 32'h0; o_done <= 1'b0;
            o_ce_n <= 1'b1; o_we_n <= 1'b1; o_oe_n <= 1'b1; o_dq_oe_n <= 1'b1;
        end else begin
            state <= next_state; cnt <= next_cnt; wr <= next_wr; rdata <= next_rdata;
            o_addr <= next_addr; o_dq <= next_dq; o_done <= next_done;
            o_ce_n <= next_ce_n; o_we_n <= next_we_n; o_oe_n <= next_oe_n;
            o_dq_oe_n <= next_dq_oe_n;
        end
    end
    assign o_busy  = (state != FCB_IDLE);
    assign o_rdata = rdata;
endmodule // fcd_bus_cycle
`default_nettype wire

// ---- design/fcd_host.sv ----
// flash command host: expands commands into write and read bus cycles
`timescale 1ns/100ps
`default_nettype none
`include "fcd_map.svh"
// Function
// - unprotect: two unlocks, E0 setup, then 01 to enable or 00 to disable.
// - command cycles only need the low data byte; upper lines driven zero.
// - F0 at any address returns to array read; used to leave autoselect.
// - bypass entry 555/20 first; then bypass program is A0 then address/value.
// - leave bypass with 90 then 00 at any address.
// - autoselect is three writes ending 90, then a read cycle.
// - identification read over consecutive reads at offsets 01, 0E, 0F.
module fcd_host (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_req_valid,
    input  wire fcd_pkg::fcd_req_s i_req,
    input  wire logic [31:0]       i_dq,
    output logic                   o_req_ready,
    output logic                   o_rsp_valid,
    output logic [31:0]            o_rsp_data,
    output logic                   o_bypass,
    output logic                   o_suspended,
    output logic [19:0]            o_addr,
    output logic [31:0]            o_dq,
    output logic                   o_dq_oe_n,
    output logic                   o_ce_n,
    output logic                   o_we_n,
    output logic                   o_oe_n
);
    typedef enum logic [1:0] {FCH_IDLE, FCH_ISSUE, FCH_WAIT} fcd_hst_state_e;
    fcd_hst_state_e    state, next_state;
    fcd_pkg::fcd_req_s req, next_req;
    logic [2:0]        step, next_step;
    logic              bypass, next_bypass, susp, next_susp, erasing, next_erasing;
    logic              ready, next_ready, rsp_v, next_rsp_v;
    logic [31:0]       rsp_d, next_rsp_d;
    fcd_pkg::fcd_cycle_s cyc;
    logic              start, busy, done;
    logic [31:0]       rdata;

    // command byte with upper data lines held low
    function automatic logic [31:0] cmd_byte(input logic [7:0] b);
        return {24'h0, b};
    endfunction

    // build one bus cycle
    function automatic fcd_pkg::fcd_cycle_s mk(input logic [19:0] a, input logic [31:0] d,
                                               input logic w, input logic l);
        mk.addr = a; mk.data = d; mk.wr = w; mk.last = l;
    endfunction

    // step table: the cycle sent at each position of each command
    always_comb begin
        logic [19:0] sa;
        logic [7:0]  pre;
        sa  = {req.addr[19:`FCD_SECTOR_LSB], 12'h0};
        pre = `FCD_D_AUTOSEL;
        cyc = mk(`FCD_ADDR_ANY, cmd_byte(`FCD_D_RESET), 1'b1, 1'b1);
        unique case (req.cmd)
            fcd_pkg::FCD_CMD_PROGRAM:       pre = `FCD_D_PROGRAM;
            fcd_pkg::FCD_CMD_BYPASS_ENTER:  pre = `FCD_D_BYPASS;
            fcd_pkg::FCD_CMD_CHIP_ERASE,
            fcd_pkg::FCD_CMD_SECTOR_ERASE:  pre = `FCD_D_ERASE_SETUP;
            fcd_pkg::FCD_CMD_REGION_ENTER:  pre = `FCD_D_REGION_ENTER;
            fcd_pkg::FCD_CMD_UNPROTECT:     pre = `FCD_D_UNPROT_SETUP;
            default:                        pre = `FCD_D_AUTOSEL;
        endcase
        unique case (req.cmd)
            fcd_pkg::FCD_CMD_RESET: ;
            fcd_pkg::FCD_CMD_READ:
                cyc = mk(req.addr, 32'h0, 1'b0, 1'b1);
            fcd_pkg::FCD_CMD_SUSPEND:
                cyc = mk(`FCD_ADDR_ANY, cmd_byte(`FCD_D_SUSPEND), 1'b1, 1'b1);
            fcd_pkg::FCD_CMD_RESUME:
                cyc = mk(`FCD_ADDR_ANY, cmd_byte(`FCD_D_RESUME), 1'b1, 1'b1);
            fcd_pkg::FCD_CMD_QUERY:
                cyc = mk(`FCD_ADDR_QUERY, cmd_byte(`FCD_D_QUERY), 1'b1, 1'b1);
            fcd_pkg::FCD_CMD_BYPASS_PROGRAM:
                cyc = (step == 3'd0) ? mk(`FCD_ADDR_ANY, cmd_byte(`FCD_D_PROGRAM), 1'b1, 1'b0)
                                     : mk(req.addr, req.data, 1'b1, 1'b1);
            fcd_pkg::FCD_CMD_BYPASS_EXIT:
                cyc = (step == 3'd0) ? mk(`FCD_ADDR_ANY, cmd_byte(`FCD_D_AUTOSEL), 1'b1, 1'b0)
                                     : mk(`FCD_ADDR_ANY, cmd_byte(`FCD_D_ZERO), 1'b1, 1'b1);
            default: begin
                unique case (step)
                    3'd0, 3'd3: cyc = mk(`FCD_ADDR_UNLOCK1, cmd_byte(`FCD_D_UNLOCK1), 1'b1, 1'b0);
                    3'd1, 3'd4: cyc = mk(`FCD_ADDR_UNLOCK2, cmd_byte(`FCD_D_UNLOCK2), 1'b1, 1'b0);
                    3'd2: cyc = mk(`FCD_ADDR_UNLOCK1, cmd_byte(pre), 1'b1,
                                   req.cmd == fcd_pkg::FCD_CMD_BYPASS_ENTER ||
                                   req.cmd == fcd_pkg::FCD_CMD_REGION_ENTER);
                    default: cyc = mk(`FCD_ADDR_ANY, 32'h0, 1'b1, 1'b1);
                endcase
                // erases send two more unlocks before their final write
                if ((step == 3'd3 && pre != `FCD_D_ERASE_SETUP) || step == 3'd5) begin
                    unique case (req.cmd)
                        fcd_pkg::FCD_CMD_PROGRAM:
                            cyc = mk(req.addr, req.data, 1'b1, 1'b1);
                        fcd_pkg::FCD_CMD_UNPROTECT:
                            cyc = mk(`FCD_ADDR_ANY, cmd_byte(req.flag ? `FCD_D_UNPROT_ON
                                     : `FCD_D_ZERO), 1'b1, 1'b1);
                        fcd_pkg::FCD_CMD_REGION_EXIT:
                            cyc = mk(`FCD_ADDR_ANY, cmd_byte(`FCD_D_ZERO), 1'b1, 1'b1);
                        fcd_pkg::FCD_CMD_AUTOSEL_QUERY:
                            cyc = mk(req.addr, 32'h0, 1'b0, 1'b1);
                        fcd_pkg::FCD_CMD_AUTOSEL_ID:
                            cyc = mk(step == 3'd3 ? `FCD_ID_OFS1 : `FCD_ID_OFS3, 32'h0,
                                     1'b0, step == 3'd5);
                        fcd_pkg::FCD_CMD_CHIP_ERASE:
                            cyc = mk(`FCD_ADDR_UNLOCK1, cmd_byte(`FCD_D_CHIP_ERASE), 1'b1, 1'b1);
                        fcd_pkg::FCD_CMD_SECTOR_ERASE:
                            cyc = mk(sa, cmd_byte(`FCD_D_SECTOR_ERASE), 1'b1, 1'b1);
                        default: ;
                    endcase
                end
                if (step == 3'd4 && req.cmd == fcd_pkg::FCD_CMD_AUTOSEL_ID)
                    cyc = mk(`FCD_ID_OFS2, 32'h0, 1'b0, 1'b0);
            end
        endcase
    end

    // sequencing and mode tracking
    always_comb begin
        next_state = state; next_req = req; next_step = step;
        next_bypass = bypass; next_susp = susp; next_erasing = erasing;
        next_ready = ready; next_rsp_v = 1'b0; next_rsp_d = rsp_d; start = 1'b0;
        unique case (state)
            FCH_IDLE: if (i_req_valid && ready) begin
                next_req = i_req; next_step = 3'd0;
                next_ready = 1'b0; next_state = FCH_ISSUE;
                // bypass mode allows only bypass program and exit
                if (bypass && i_req.cmd != fcd_pkg::FCD_CMD_BYPASS_PROGRAM &&
                    i_req.cmd != fcd_pkg::FCD_CMD_BYPASS_EXIT) next_state = FCH_WAIT;
                if (!bypass && i_req.cmd == fcd_pkg::FCD_CMD_BYPASS_PROGRAM)
                    next_state = FCH_WAIT;
                if (i_req.cmd == fcd_pkg::FCD_CMD_SUSPEND && !erasing)
                    next_state = FCH_WAIT;
                if (i_req.cmd == fcd_pkg::FCD_CMD_RESUME && !susp)
                    next_state = FCH_WAIT;
                if (susp && (i_req.cmd == fcd_pkg::FCD_CMD_CHIP_ERASE ||
                    i_req.cmd == fcd_pkg::FCD_CMD_SECTOR_ERASE ||
                    i_req.cmd == fcd_pkg::FCD_CMD_BYPASS_ENTER))
                    next_state = FCH_WAIT;
            end
            FCH_ISSUE: begin
                start = 1'b1;
                next_state = FCH_WAIT;
            end
            FCH_WAIT: if (!busy) begin
                if (done && !cyc.last) begin
                    next_step = step + 3'd1;
                    next_state = FCH_ISSUE;
                    if (!cyc.wr) begin
                        next_rsp_v = 1'b1; next_rsp_d = rdata;
                    end
                end else begin
                    if (done) begin
                        if (!cyc.wr) begin
                            next_rsp_v = 1'b1; next_rsp_d = rdata;
                        end
                        unique case (req.cmd)
                            fcd_pkg::FCD_CMD_BYPASS_ENTER: next_bypass = 1'b1;
                            fcd_pkg::FCD_CMD_BYPASS_EXIT:  next_bypass = 1'b0;
                            fcd_pkg::FCD_CMD_SECTOR_ERASE: next_erasing = 1'b1;
                            fcd_pkg::FCD_CMD_SUSPEND:      next_susp = 1'b1;
                            fcd_pkg::FCD_CMD_RESUME:       next_susp = 1'b0;
                            default: ;
                        endcase
                        if (req.cmd == fcd_pkg::FCD_CMD_RESET && !susp) begin
                            next_erasing = 1'b0;
                        end
                    end
                    next_ready = 1'b1;
                    next_state = FCH_IDLE;
                end
            end
            default: next_state = FCH_IDLE;
        endcase
    end

    // register sequencing state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= FCH_IDLE; req <= '0; step <= 3'd0;
            bypass <= 1'b0; susp <= 1'b0; erasing <= 1'b0;
            ready <= 1'b1; rsp_v <= 1'b0; rsp_d <= 32'h0;
        end else begin
            state <= next_state; req <= next_req; step <= next_step;
            bypass <= next_bypass; susp <= next_susp; erasing <= next_erasing;
            ready <= next_ready; rsp_v <= next_rsp_v; rsp_d <= next_rsp_d;
        end
    end

    // bus cycle engine
    fcd_bus_cycle u_cycle (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_start   (start),
        .i_cyc     (cyc),
        .i_dq      (i_dq),
        .o_busy    (busy),
        .o_done    (done),
        .o_rdata   (rdata),
        .o_addr    (o_addr),
        .o_dq      (o_dq),
        .o_dq_oe_n (o_dq_oe_n),
        .o_ce_n    (o_ce_n),
        .o_we_n    (o_we_n),
        .o_oe_n    (o_oe_n)
    );
    assign o_req_ready = ready;
    assign o_rsp_valid = rsp_v;
    assign o_rsp_data  = rsp_d;
    assign o_bypass    = bypass;
    assign o_suspended = susp;

    // write cycles carry only the low command byte outside program data
    AST_UPPER_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        start && cyc.wr && req.cmd != fcd_pkg::FCD_CMD_PROGRAM &&
        req.cmd != fcd_pkg::FCD_CMD_BYPASS_PROGRAM |-> cyc.data[31:8] == 24'h0)
        else $error("upper data lines not zero in command cycle");
    AST_PROG_FIRST: assert property (@(posedge i_clk) disable iff (i_rst)
        start && req.cmd == fcd_pkg::FCD_CMD_PROGRAM && step == 3'd0
        |-> cyc.addr == `FCD_ADDR_UNLOCK1 && cyc.data[7:0] == `FCD_D_UNLOCK1)
        else $error("program does not open with unlock");
    AST_BYPASS_GATE: assert property (@(posedge i_clk) disable iff (i_rst)
        start && req.cmd == fcd_pkg::FCD_CMD_BYPASS_PROGRAM |-> bypass)
        else $error("bypass program outside bypass mode");
    AST_SUSPEND_GATE: assert property (@(posedge i_clk) disable iff (i_rst)
        start && req.cmd == fcd_pkg::FCD_CMD_SUSPEND |-> erasing)
        else $error("suspend sent with no sector erase");
    AST_RESUME_GATE: assert property (@(posedge i_clk) disable iff (i_rst)
        start && req.cmd == fcd_pkg::FCD_CMD_RESUME |-> susp)
        else $error("resume sent while not suspended");
    AST_ERASE_LAST: assert property (@(posedge i_clk) disable iff (i_rst)
        start && req.cmd == fcd_pkg::FCD_CMD_SECTOR_ERASE && step == 3'd5
        |-> cyc.data[7:0] == `FCD_D_SECTOR_ERASE && cyc.addr[11:0] == 12'h0)
        else $error("sector erase final write wrong");
    AST_ID_READS: assert property (@(posedge i_clk) disable iff (i_rst)
        start && req.cmd == fcd_pkg::FCD_CMD_AUTOSEL_ID && step == 3'd3
        |-> !cyc.wr && cyc.addr == `FCD_ID_OFS1)
        else $error("identification read offset wrong");
    AST_EXIT_CLEARS: assert property (@(posedge i_clk) disable iff (i_rst)
        done && state == FCH_WAIT && cyc.last && req.cmd == fcd_pkg::FCD_CMD_BYPASS_EXIT
        |=> !bypass)
        else $error("bypass flag kept after exit");
endmodule // fcd_host
`default_nettype wire

// ---- sim/fcd_flash_model.sv ----
// behavioural flash device on the far side of the command host
`timescale 1ns/100ps
`default_nettype none
module fcd_flash_model #(
    parameter logic [31:0] ID_A   = 32'h0000_1c01, // arbitrary id code
    parameter logic [31:0] ID_B   = 32'h0000_1c0e, // arbitrary id code
    parameter logic [31:0] ID_C   = 32'h0000_1c0f, // arbitrary id code
    parameter logic [7:0]  PROT   = 8'h05,
    parameter logic        GUARD_LOW = 1'b0,
    parameter logic        LOCKED = 1'b1
) (
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic [19:0] i_addr,
    input  wire logic [31:0] i_dq,
    output logic [31:0]      o_dq
);
    logic [19:0] a_lat;
    logic [27:0] wlog[$];
    logic [31:0] mem[logic [19:0]];
    logic        autosel = 1'b0;
    logic        prg     = 1'b0;
    logic        unprot  = 1'b0;
    logic        unp_setup = 1'b0;
    logic [31:0] held    = 32'h0;
    logic [31:0] rd;
    // address taken on the falling strobe
    always @(negedge i_we_n) if (!i_ce_n) a_lat = i_addr;
    // decode on the rising strobe, low data byte only
    always @(posedge i_we_n) if (!i_ce_n) begin
        if (prg) mem[a_lat] = i_dq;
        prg = !prg && (i_dq[7:0] == 8'ha0);
        wlog.push_back({a_lat, i_dq[7:0]});
        if (unp_setup) unprot = (i_dq[7:0] == 8'h01);
        unp_setup = (i_dq[7:0] == 8'he0) && a_lat[10:0] == 11'h555;
        if (i_dq[7:0] == 8'hf0) autosel = 1'b0;
        if (i_dq[7:0] == 8'h90 && a_lat[10:0] == 11'h555) autosel = 1'b1;
    end
    // array or identification data
    always @* begin
        rd = mem.exists(i_addr) ? mem[i_addr] : 32'hffff_ffff;
        if (autosel) begin
            case (i_addr[7:0])
                8'h01: rd = ID_A;
                8'h0e: rd = ID_B;
                8'h0f: rd = ID_C;
                // unprotect clears protection except a guarded boot sector
                8'h02: rd = {31'h0, i_addr[19:12] == PROT &&
                             (!unprot || (GUARD_LOW && i_addr[19:12] == 8'h00))};
                8'h03: rd = LOCKED ? 32'h80 : 32'h0;
                default: ;
            endcase
        end
    end
    // released bus shows the inverse of the last value
    always @(posedge i_oe_n) held <= ~rd;
    assign o_dq = (!i_ce_n && !i_oe_n) ? rd : held;
endmodule // fcd_flash_model
`default_nettype wire

// ---- sim/fcd_tb.sv ----
// self-checking bench for the flash command host
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [27:0] U1 = 28'h00555aa, U2 = 28'h002aa55, AS = 28'h0055590;
    localparam logic [27:0] RS = 28'h00000f0;
    logic               i_clk = 0, i_rst = 1, i_req_valid = 0;
    fcd_pkg::fcd_req_s  i_req = '0;
    logic [31:0]        fdq, o_rsp_data, o_dq;
    logic [19:0]        o_addr;
    logic               o_req_ready, o_rsp_valid, o_bypass, o_suspended;
    logic               o_dq_oe_n, o_ce_n, o_we_n, o_oe_n;
    int                 bad_count = 0, tests_run = 0, cycles = 0;
    logic [31:0]        rsp[$];
    fcd_host dut (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
        .i_dq(fdq), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
        .o_rsp_data(o_rsp_data), .o_bypass(o_bypass), .o_suspended(o_suspended),
        .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .o_ce_n(o_ce_n),
        .o_we_n(o_we_n), .o_oe_n(o_oe_n));
    fcd_flash_model flash (.i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
        .i_addr(o_addr), .i_dq(o_dq_oe_n ? 32'h0 : o_dq), .o_dq(fdq));
    // clock, response capture and hang guard
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_rsp_valid === 1'b1) rsp.push_back(o_rsp_data);
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_log(input string what, input logic [27:0] e[$]);
        chk({what, " count"}, 32'(e.size()), 32'(flash.wlog.size()));
        foreach (e[i]) chk(what, {4'h0, e[i]}, {4'h0, flash.wlog[i]});
        flash.wlog.delete();
    endtask
    // one request, then wait for the host to be ready again
    task automatic run(input fcd_pkg::fcd_cmd_e c, input logic [19:0] a = 20'h0,
                       input logic [31:0] d = 32'h0, input logic f = 1'b0);
        int n;
        n = 0;
        @(negedge i_clk);
        i_req = '{cmd: c, addr: a, data: d, flag: f};
        i_req_valid = 1'b1;
        @(negedge i_clk);
        i_req_valid = 1'b0;
        repeat (4) @(negedge i_clk);
        while (o_req_ready !== 1'b1 && n < 3000) begin
            @(negedge i_clk);
            n++;
        end
        chk("ready", 32'h1, {31'h0, o_req_ready});
        // let the capture take a read that ends with ready
        @(negedge i_clk);
    endtask
    task automatic t_program();
        run(fcd_pkg::FCD_CMD_PROGRAM, 20'h12344, 32'hcafe_f00d);
        chk_log("program", '{U1, U2, 28'h00555a0, 28'h123440d});
        chk("stored", 32'hcafe_f00d, flash.mem[20'h12344]);
        run(fcd_pkg::FCD_CMD_READ, 20'h12344);
        chk("read", 32'hcafe_f00d, rsp.pop_front());
    endtask
    task automatic t_bypass();
        run(fcd_pkg::FCD_CMD_BYPASS_ENTER);
        chk("bypass on", 32'h1, {31'h0, o_bypass});
        run(fcd_pkg::FCD_CMD_PROGRAM, 20'h00900, 32'h1);
        run(fcd_pkg::FCD_CMD_BYPASS_PROGRAM, 20'h00800, 32'h1234_5678);
        run(fcd_pkg::FCD_CMD_BYPASS_EXIT);
        chk("bypass off", 32'h0, {31'h0, o_bypass});
        chk_log("bypass", '{U1, U2, 28'h0055520, 28'h00000a0, 28'h0080078, 28'h0000090,
            28'h0000000});
        chk("bp stored", 32'h1234_5678, flash.mem[20'h00800]);
    endtask
    task automatic t_erase();
        run(fcd_pkg::FCD_CMD_SUSPEND);
        chk("idle suspend", 32'h0, 32'(flash.wlog.size()));
        run(fcd_pkg::FCD_CMD_SECTOR_ERASE, 20'h34000);
        run(fcd_pkg::FCD_CMD_SUSPEND);
        chk("suspended", 32'h1, {31'h0, o_suspended});
        run(fcd_pkg::FCD_CMD_READ, 20'h12344);
        chk("read in suspend", 32'hcafe_f00d, rsp.pop_front());
        run(fcd_pkg::FCD_CMD_RESUME);
        chk("resumed", 32'h0, {31'h0, o_suspended});
        run(fcd_pkg::FCD_CMD_RESUME);
        run(fcd_pkg::FCD_CMD_RESET);
        chk_log("erase", '{U1, U2, 28'h0055580, U1, U2, 28'h3400030, 28'h00000b0,
            28'h0000030, RS});
    endtask
    task automatic t_autosel();
        run(fcd_pkg::FCD_CMD_AUTOSEL_ID);
        chk("id a", flash.ID_A, rsp.pop_front());
        chk("id b", flash.ID_B, rsp.pop_front());
        chk("id c", flash.ID_C, rsp.pop_front());
        run(fcd_pkg::FCD_CMD_RESET);
        run(fcd_pkg::FCD_CMD_AUTOSEL_QUERY, 20'h00003);
        chk("lock", 32'h80, rsp.pop_front());
        run(fcd_pkg::FCD_CMD_RESET);
        run(fcd_pkg::FCD_CMD_AUTOSEL_QUERY, 20'h05002);
        chk("prot", 32'h1, rsp.pop_front());
        run(fcd_pkg::FCD_CMD_RESET);
        chk_log("autosel", '{U1, U2, AS, RS, U1, U2, AS, RS, U1, U2, AS, RS});
    endtask
    task automatic t_misc();
        run(fcd_pkg::FCD_CMD_CHIP_ERASE);
        chk_log("chip", '{U1, U2, 28'h0055580, U1, U2, 28'h0055510});
        run(fcd_pkg::FCD_CMD_REGION_ENTER);
        run(fcd_pkg::FCD_CMD_REGION_EXIT);
        chk_log("region", '{U1, U2, 28'h0055588, U1, U2, AS, 28'h0000000});
        run(fcd_pkg::FCD_CMD_QUERY);
        chk_log("query", '{28'h0005598});
        run(fcd_pkg::FCD_CMD_UNPROTECT, 20'h0, 32'h0, 1'b1);
        run(fcd_pkg::FCD_CMD_AUTOSEL_QUERY, 20'h05002);
        chk("unprot on", 32'h0, rsp.pop_front());
        run(fcd_pkg::FCD_CMD_RESET);
        run(fcd_pkg::FCD_CMD_UNPROTECT, 20'h0, 32'h0, 1'b0);
        run(fcd_pkg::FCD_CMD_AUTOSEL_QUERY, 20'h05002);
        chk("unprot off", 32'h1, rsp.pop_front());
        run(fcd_pkg::FCD_CMD_RESET);
        chk_log("unprot", '{U1, U2, 28'h00555e0, 28'h0000001, U1, U2, AS, RS, U1, U2,
            28'h00555e0, 28'h0000000, U1, U2, AS, RS});
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (10) @(negedge i_clk);
        i_rst = 1'b0;
        chk("idle strobes", 32'h7, {29'h0, o_ce_n, o_we_n, o_oe_n});
        t_program();
        t_bypass();
        t_erase();
        t_autosel();
        t_misc();
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
